// ===== pkg/wdspc_pkg.sv
// Package for the watchdog and soft power-off controller
package wdspc_pkg;
	localparam logic [7:0] WDSPC_CFG_IDX = 8'hf3;
	localparam logic [7:0] WDSPC_CTRL_IDX = 8'hf4;
	localparam logic [7:0] WDSPC_UNITS_IDX = 8'hf1;
	localparam logic [7:0] WDSPC_TOVAL_IDX = 8'hf2;
	localparam logic [7:0] WDSPC_DLY_IDX = 8'hb8;
	localparam logic [11:0] WDSPC_CFG_ADDR = 12'h3cc;
	localparam logic [11:0] WDSPC_CTRL_ADDR = 12'h3d0;
	localparam logic [11:0] WDSPC_UNITS_ADDR = 12'h3c4;
	localparam logic [11:0] WDSPC_TOVAL_ADDR = 12'h3c8;
	localparam logic [11:0] WDSPC_DLY_ADDR = 12'h2e0;
	localparam logic [11:0] WDSPC_IRQ_STAT_ADDR = 12'h400;
	localparam logic [11:0] WDSPC_IRQ_MASK_ADDR = 12'h404;
	localparam logic [7:0] WDSPC_CFG_RST = 8'h00;
	localparam logic [7:0] WDSPC_CTRL_RST = 8'h00;
	localparam logic [7:0] WDSPC_DLY_RST = 8'h05;
	localparam int WDSPC_B_GAME = 0;
	localparam int WDSPC_B_KBD = 1;
	localparam int WDSPC_B_MOUSE = 2;
	localparam int WDSPC_B_LEDTO = 3;
	localparam int WDSPC_B_STAT = 0;
	localparam int WDSPC_B_LEDEN = 1;
	localparam int WDSPC_B_FORCE = 2;
	localparam int WDSPC_B_KBDF = 3;
	localparam int WDSPC_B_STOP = 5;
	localparam int WDSPC_B_RESTART = 6;
	localparam int WDSPC_B_POFF = 7;
	localparam int WDSPC_B_UNITS = 7;
	localparam logic [3:0] WDSPC_MAP_OFF = 4'h0;
	localparam logic [3:0] WDSPC_MAP_IRQ1 = 4'h1;
	localparam logic [3:0] WDSPC_MAP_BAD = 4'h2;
	localparam logic [3:0] WDSPC_MAP_IRQ3 = 4'h3;
	localparam logic [3:0] WDSPC_MAP_IRQ15 = 4'hf;
	localparam int WDSPC_CLK_MHZ = 250;
	localparam int WDSPC_HALF_SEC_MS = 500;
	localparam int WDSPC_DLY_STEP_MS = 100;
	localparam int WDSPC_SEC_PER_MIN = 60;
	localparam int WDSPC_SEC_CYC = WDSPC_CLK_MHZ * 1000000;
	localparam int WDSPC_HALF_CYC = WDSPC_CLK_MHZ * 1000 * WDSPC_HALF_SEC_MS;
	localparam int WDSPC_STEP_CYC = WDSPC_CLK_MHZ * 1000 * WDSPC_DLY_STEP_MS;
	typedef struct packed {
		logic irq1;
		logic irq3;
		logic irq15;
	} wdspc_irq_type;
	typedef struct packed {
		logic to_event;
		logic poff;
	} wdspc_evt_type;
endpackage

// ===== hdl/wdspc_top.sv
// Watchdog timer and soft power-off controller
`timescale 1ns/1ps
module wdspc_top #(
	parameter int SEC_CYC = wdspc_pkg::WDSPC_SEC_CYC,
	parameter int HALF_CYC = wdspc_pkg::WDSPC_HALF_CYC,
	parameter int STEP_CYC = wdspc_pkg::WDSPC_STEP_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic game_port_access,
	input wire logic kbd_irq,
	input wire logic mouse_irq,
	input wire logic kbd_ctrl_reset_out,
	input wire logic power_button,
	output logic power_indicator_output,
	output logic soft_poweroff_request,
	output wdspc_pkg::wdspc_irq_type host_irq,
	output logic irq
);
	logic [7:0] cfg_q, ctrl_q, toval_q, dly_q;
	logic units_q;
	logic [1:0] ist_q, imask_q;
	logic aw_hold_q, w_hold_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [2:0] game_s_q, kbd_s_q, mouse_s_q, p20_s_q, btn_s_q;
	logic force_q, restart_q, stop_q, poff_q;
	logic [31:0] sec_cnt_q, half_cnt_q, step_cnt_q;
	logic [5:0] min_cnt_q;
	logic [7:0] wd_cnt_q, dly_cnt_q;
	logic dly_run_q, blink_q;
	wdspc_pkg::wdspc_irq_type host_irq_q;
	logic pwr_ind_q, poff_out_q, irq_q;
	logic do_wr, wr_ctrl, reload, to_trig, sec_tick, unit_tick, expire;
	logic half_tick, step_tick;
	logic aw_hold_d, w_hold_d, bvalid_d, awready_q, wready_q, arready_q, dly_stop_q;
	wdspc_pkg::wdspc_evt_type evt;

	// Pins pass two flops; third is history for edges
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			game_s_q <= 3'h0;
			kbd_s_q <= 3'h0;
			mouse_s_q <= 3'h0;
			p20_s_q <= 3'h0;
			btn_s_q <= 3'h0;
		end else begin
			game_s_q <= {game_s_q[1:0], game_port_access};
			kbd_s_q <= {kbd_s_q[1:0], kbd_irq};
			mouse_s_q <= {mouse_s_q[1:0], mouse_irq};
			p20_s_q <= {p20_s_q[1:0], kbd_ctrl_reset_out};
			btn_s_q <= {btn_s_q[1:0], power_button};
		end
	end

	// AXI write: address and data in any order
	// Readies built from next state so they leave flops
	always_comb begin
		aw_hold_d = aw_hold_q || (s_axi_awvalid && s_axi_awready);
		w_hold_d = w_hold_q || (s_axi_wvalid && s_axi_wready);
		bvalid_d = s_axi_bvalid && !s_axi_bready;
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			s_axi_bvalid <= bvalid_d;
			awready_q <= !aw_hold_d && !bvalid_d;
			wready_q <= !w_hold_d && !bvalid_d;
		end
	end
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bresp = 2'b00;
	assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign wr_ctrl = do_wr && wstrb_q[0] && awaddr_q[11:2] == wdspc_pkg::WDSPC_CTRL_ADDR[11:2];

	// AXI read; unmapped reads return zero with OKAY
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			arready_q <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			arready_q <= 1'b0;
			case (s_axi_araddr[11:2])
				wdspc_pkg::WDSPC_CFG_ADDR[11:2]: s_axi_rdata <= {24'h0, cfg_q};
				// Control read shows status, stop flag, enables
				wdspc_pkg::WDSPC_CTRL_ADDR[11:2]: s_axi_rdata <= {24'h0, 2'b00, dly_stop_q, 1'b0,
					ctrl_q[wdspc_pkg::WDSPC_B_KBDF], 1'b0, ctrl_q[wdspc_pkg::WDSPC_B_LEDEN],
					ctrl_q[wdspc_pkg::WDSPC_B_STAT]};
				wdspc_pkg::WDSPC_UNITS_ADDR[11:2]: s_axi_rdata <= {24'h0, units_q, 7'h00};
				wdspc_pkg::WDSPC_TOVAL_ADDR[11:2]: s_axi_rdata <= {24'h0, toval_q};
				wdspc_pkg::WDSPC_DLY_ADDR[11:2]: s_axi_rdata <= {24'h0, dly_q};
				wdspc_pkg::WDSPC_IRQ_STAT_ADDR[11:2]: s_axi_rdata <= {30'h0, ist_q};
				wdspc_pkg::WDSPC_IRQ_MASK_ADDR[11:2]: s_axi_rdata <= {30'h0, imask_q};
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			arready_q <= 1'b1;
		end else begin
			arready_q <= !s_axi_rvalid;
		end
	end
	assign s_axi_arready = arready_q;
	assign s_axi_rresp = 2'b00;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg_q <= wdspc_pkg::WDSPC_CFG_RST;
			units_q <= 1'b0;
			toval_q <= 8'h00;
			dly_q <= wdspc_pkg::WDSPC_DLY_RST;
			imask_q <= 2'h0;
		end else if (do_wr && wstrb_q[0]) begin
			case (awaddr_q[11:2])
				wdspc_pkg::WDSPC_CFG_ADDR[11:2]: cfg_q <= wdata_q[7:0];
				wdspc_pkg::WDSPC_UNITS_ADDR[11:2]: units_q <= wdata_q[wdspc_pkg::WDSPC_B_UNITS];
				wdspc_pkg::WDSPC_TOVAL_ADDR[11:2]: toval_q <= wdata_q[7:0];
				wdspc_pkg::WDSPC_DLY_ADDR[11:2]: dly_q <= wdata_q[7:0];
				wdspc_pkg::WDSPC_IRQ_MASK_ADDR[11:2]: imask_q <= wdata_q[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			force_q <= 1'b0;
			restart_q <= 1'b0;
			stop_q <= 1'b0;
			poff_q <= 1'b0;
		end else begin
			force_q <= wr_ctrl && wdata_q[wdspc_pkg::WDSPC_B_FORCE];
			restart_q <= wr_ctrl && wdata_q[wdspc_pkg::WDSPC_B_RESTART];
			stop_q <= wr_ctrl && wdata_q[wdspc_pkg::WDSPC_B_STOP];
			poff_q <= wr_ctrl && wdata_q[wdspc_pkg::WDSPC_B_POFF];
		end
	end

	// edge pulse ORed with force bit
	assign to_trig = force_q || (ctrl_q[wdspc_pkg::WDSPC_B_KBDF] && p20_s_q[1] && !p20_s_q[2]);
	assign reload = (cfg_q[wdspc_pkg::WDSPC_B_GAME] && game_s_q[1] && !game_s_q[2])
		|| (cfg_q[wdspc_pkg::WDSPC_B_KBD] && kbd_s_q[1] && !kbd_s_q[2])
		|| (cfg_q[wdspc_pkg::WDSPC_B_MOUSE] && mouse_s_q[1] && !mouse_s_q[2]);

	// Time bases: seconds, minutes, half seconds, delay steps
	assign sec_tick = sec_cnt_q == 32'(SEC_CYC - 1);
	assign half_tick = half_cnt_q == 32'(HALF_CYC - 1);
	assign step_tick = step_cnt_q == 32'(STEP_CYC - 1);
	assign unit_tick = sec_tick && (units_q || min_cnt_q == 6'(wdspc_pkg::WDSPC_SEC_PER_MIN - 1));
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sec_cnt_q <= 32'h0;
			half_cnt_q <= 32'h0;
			step_cnt_q <= 32'h0;
			min_cnt_q <= 6'h00;
		end else begin
			sec_cnt_q <= (sec_tick || reload) ? 32'h0 : sec_cnt_q + 32'h1;
			half_cnt_q <= half_tick ? 32'h0 : half_cnt_q + 32'h1;
			step_cnt_q <= (step_tick || restart_q) ? 32'h0 : step_cnt_q + 32'h1;
			if (reload || unit_tick) begin
				min_cnt_q <= 6'h00;
			end else if (sec_tick) begin
				min_cnt_q <= min_cnt_q + 6'h01;
			end
		end
	end

	assign expire = toval_q != 8'h00 && unit_tick && wd_cnt_q == toval_q - 8'h01;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wd_cnt_q <= 8'h00;
		end else if (reload || expire || toval_q == 8'h00) begin
			wd_cnt_q <= 8'h00;
		end else if (unit_tick && !ctrl_q[wdspc_pkg::WDSPC_B_STAT]) begin
			wd_cnt_q <= wd_cnt_q + 8'h01;
		end
	end

	// status flag; a timeout wins over a clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl_q <= wdspc_pkg::WDSPC_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_q[wdspc_pkg::WDSPC_B_STAT] <= wdata_q[wdspc_pkg::WDSPC_B_STAT];
				ctrl_q[wdspc_pkg::WDSPC_B_LEDEN] <= wdata_q[wdspc_pkg::WDSPC_B_LEDEN];
				ctrl_q[wdspc_pkg::WDSPC_B_KBDF] <= wdata_q[wdspc_pkg::WDSPC_B_KBDF];
			end
			if (expire || to_trig) begin
				ctrl_q[wdspc_pkg::WDSPC_B_STAT] <= 1'b1;
			end
		end
	end

	// stop ends delay; restart from zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dly_run_q <= 1'b0;
			dly_cnt_q <= 8'h00;
		end else if (stop_q) begin
			dly_run_q <= 1'b0;
		end else if (restart_q || (btn_s_q[1] && !btn_s_q[2])) begin
			dly_run_q <= 1'b1;
			dly_cnt_q <= 8'h00;
		end else if (dly_run_q && step_tick) begin
			if (dly_cnt_q + 8'h01 >= dly_q) begin
				dly_run_q <= 1'b0;
			end
			dly_cnt_q <= dly_cnt_q + 8'h01;
		end
	end
	// stop flag reads zero until a stop
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dly_stop_q <= 1'b0;
		end else if (stop_q) begin
			dly_stop_q <= 1'b1;
		end else if (restart_q || (btn_s_q[1] && !btn_s_q[2])) begin
			dly_stop_q <= 1'b0;
		end
	end
	assign evt.to_event = expire || to_trig;
	assign evt.poff = poff_q || (dly_run_q && step_tick && !stop_q && !restart_q
		&& dly_cnt_q + 8'h01 >= dly_q);

	// blink on timeout; blink on enable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			blink_q <= 1'b0;
			pwr_ind_q <= 1'b0;
		end else begin
			if (half_tick) begin
				blink_q <= !blink_q;
			end
			if (ctrl_q[wdspc_pkg::WDSPC_B_LEDEN]
				|| (cfg_q[wdspc_pkg::WDSPC_B_LEDTO] && ctrl_q[wdspc_pkg::WDSPC_B_STAT])) begin
				pwr_ind_q <= blink_q;
			end else begin
				pwr_ind_q <= 1'b1;
			end
		end
	end

	// interrupt routing; invalid codes drive none
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			host_irq_q <= '0;
		end else begin
			host_irq_q.irq1 <= ctrl_q[wdspc_pkg::WDSPC_B_STAT] && cfg_q[7:4] == wdspc_pkg::WDSPC_MAP_IRQ1;
			host_irq_q.irq3 <= ctrl_q[wdspc_pkg::WDSPC_B_STAT] && cfg_q[7:4] == wdspc_pkg::WDSPC_MAP_IRQ3;
			host_irq_q.irq15 <= ctrl_q[wdspc_pkg::WDSPC_B_STAT] && cfg_q[7:4] == wdspc_pkg::WDSPC_MAP_IRQ15;
		end
	end

	// Sticky events; set wins over write-one clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ist_q <= 2'h0;
			poff_out_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (do_wr && wstrb_q[0] && awaddr_q[11:2] == wdspc_pkg::WDSPC_IRQ_STAT_ADDR[11:2]) begin
				ist_q <= (ist_q & ~wdata_q[1:0]) | {evt.poff, evt.to_event};
			end else begin
				ist_q <= ist_q | {evt.poff, evt.to_event};
			end
			poff_out_q <= evt.poff;
			irq_q <= |(ist_q & imask_q);
		end
	end
	assign host_irq = host_irq_q;
	assign power_indicator_output = pwr_ind_q;
	assign soft_poweroff_request = poff_out_q;
	assign irq = irq_q;

	property p_force;
		@(posedge ref_clk) disable iff (!rst_n) force_q |=> ctrl_q[wdspc_pkg::WDSPC_B_STAT];
	endproperty
	a_force: assert property (p_force) else $error("force did not set status");
	property p_kbdf;
		@(posedge ref_clk) disable iff (!rst_n)
			(p20_s_q[1] && !p20_s_q[2] && ctrl_q[wdspc_pkg::WDSPC_B_KBDF]) |=> ctrl_q[wdspc_pkg::WDSPC_B_STAT];
	endproperty
	a_kbdf: assert property (p_kbdf) else $error("edge did not time out");
	property p_selfclr;
		@(posedge ref_clk) disable iff (!rst_n) force_q |=> !force_q || $past(wr_ctrl);
	endproperty
	a_selfclr: assert property (p_selfclr) else $error("force bit stuck");
	property p_poff;
		@(posedge ref_clk) disable iff (!rst_n) poff_q |=> soft_poweroff_request;
	endproperty
	a_poff: assert property (p_poff) else $error("no power-down");
	property p_stop;
		@(posedge ref_clk) disable iff (!rst_n) stop_q |=> !dly_run_q && !soft_poweroff_request;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not halt delay");
	property p_restart;
		@(posedge ref_clk) disable iff (!rst_n) (restart_q && !stop_q) |=> dly_run_q && dly_cnt_q == 8'h00;
	endproperty
	a_restart: assert property (p_restart) else $error("restart failed");
	property p_irq15;
		@(posedge ref_clk) disable iff (!rst_n)
			(ctrl_q[wdspc_pkg::WDSPC_B_STAT] && cfg_q[7:4] == wdspc_pkg::WDSPC_MAP_IRQ15 && $stable(cfg_q))
			|=> host_irq.irq15 && !host_irq.irq1;
	endproperty
	a_irq15: assert property (p_irq15) else $error("bad irq routing");
	property p_reload;
		@(posedge ref_clk) disable iff (!rst_n) reload |=> wd_cnt_q == 8'h00;
	endproperty
	a_reload: assert property (p_reload) else $error("reload ignored");
	property p_off;
		@(posedge ref_clk) disable iff (!rst_n) (toval_q == 8'h00 && !to_trig && !wr_ctrl
			&& !ctrl_q[wdspc_pkg::WDSPC_B_STAT]) |=> !ctrl_q[wdspc_pkg::WDSPC_B_STAT];
	endproperty
	a_off: assert property (p_off) else $error("disabled timer expired");
	c_force: cover property (@(posedge ref_clk) disable iff (!rst_n) force_q);
	c_expire: cover property (@(posedge ref_clk) disable iff (!rst_n) expire);
	c_poff: cover property (@(posedge ref_clk) disable iff (!rst_n) evt.poff);
	c_reload: cover property (@(posedge ref_clk) disable iff (!rst_n) reload);
endmodule // wdspc_top

// ===== tb/wdspc_peer.sv
// Model of the event sources around the watchdog block
`timescale 1ns/1ps
module wdspc_peer #(
	parameter int KBD_HOLD = 250
) (
	input wire logic ref_clk,
	output logic [4:0] ev
);
	initial ev = 5'h00;
	// Long enough to cross the two-flop sync
	task automatic pulse(input int i);
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		repeat ((i == 3) ? KBD_HOLD : 4) @(posedge ref_clk);
		ev[i] <= 1'b0;
	endtask
	task automatic hold(input int i, input logic v);
		@(posedge ref_clk);
		ev[i] <= v;
	endtask
endmodule // wdspc_peer

// ===== tb/test_wdspc_top.sv
// Self-checking bench for the watchdog and soft power-off block
`timescale 1ns/1ps
module test_wdspc_top;
	logic ref_clk = 1'b0;
	logic rst_n;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, led, poff;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd;
	logic [4:0] ev;
	wdspc_pkg::wdspc_irq_type host_irq;
	logic [3:0] map_t [5] = '{4'hf, 4'h3, 4'h1, 4'h0, 4'h2};
	logic [2:0] irq_t [5] = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b000};
	int fails = 0;
	int check_count = 0;
	int poff_cnt = 0;
	int c0, n;
	always #2 ref_clk = ~ref_clk;
	// Short counts keep the run small
	wdspc_top #(.SEC_CYC(20), .HALF_CYC(10), .STEP_CYC(5)) dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .game_port_access(ev[0]), .kbd_irq(ev[1]), .mouse_irq(ev[2]), .kbd_ctrl_reset_out(ev[3]),
		.power_button(ev[4]), .power_indicator_output(led), .soft_poweroff_request(poff), .host_irq, .irq);
	wdspc_peer peer (.ref_clk, .ev);
	// Pulse may land before the bus answer returns
	always @(negedge ref_clk) if (poff === 1'b1) poff_cnt++;
	task automatic complete_run();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	// Ready sampled at negedge holds until the taking edge
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bit da, dw, ta, tw;
		da = 0;
		dw = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge ref_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			da |= ta;
			dw |= tw;
		end
		do begin
			@(negedge ref_clk);
			ta = s_axi_bvalid;
			@(posedge ref_clk);
		end while (!ta);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		bit t;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			t = s_axi_arready;
			@(posedge ref_clk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge ref_clk);
			t = s_axi_rvalid;
			rd = s_axi_rdata;
			@(posedge ref_clk);
		end while (!t);
		s_axi_rready <= 1'b0;
		chk(rd & m, e);
	endtask
	task automatic blink(input bit on);
		logic p;
		n = 0;
		@(negedge ref_clk);
		p = led;
		repeat (40) begin
			@(negedge ref_clk);
			if (led !== p) n++;
			p = led;
		end
		chk({31'h0, (on ? (n >= 3 && n <= 5) : (n == 0 && led === 1'b1))}, 32'h1);
	endtask
	initial begin
		rst_n <= 1'b0;
		s_axi_awaddr <= 12'h000;
		s_axi_araddr <= 12'h000;
		s_axi_wdata <= 32'h00000000;
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		cyc(6);
		rst_n <= 1'b1;
		cyc(2);
		rchk(wdspc_pkg::WDSPC_CFG_ADDR, 32'hff, 32'h0);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'hff, 32'h0);
		rchk(12'h100, 32'hffffffff, 32'h0);
		// Low byte strobe off: write must be ignored
		s_axi_wstrb <= 4'h0;
		wr(wdspc_pkg::WDSPC_CFG_ADDR, 8'h30);
		s_axi_wstrb <= 4'h1;
		rchk(wdspc_pkg::WDSPC_CFG_ADDR, 32'hff, 32'h0);
		blink(0);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h04);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h07, 32'h01);
		for (int i = 0; i < 5; i++) begin
			wr(wdspc_pkg::WDSPC_CFG_ADDR, {map_t[i], 4'h0});
			cyc(3);
			chk({29'h0, host_irq}, {29'h0, irq_t[i]});
		end
		wr(wdspc_pkg::WDSPC_IRQ_MASK_ADDR, 8'h01);
		cyc(3);
		chk({31'h0, irq}, 32'h1);
		wr(wdspc_pkg::WDSPC_IRQ_STAT_ADDR, 8'h01);
		cyc(3);
		chk({31'h0, irq}, 32'h0);
		wr(wdspc_pkg::WDSPC_CFG_ADDR, 8'h08);
		blink(1);
		wr(wdspc_pkg::WDSPC_CFG_ADDR, 8'h00);
		cyc(2);
		blink(0);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h00);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h0);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h02);
		blink(1);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h00);
		peer.pulse(3);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h0);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h08);
		peer.hold(3, 1'b1);
		cyc(6);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h1);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h08);
		cyc(10);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h0);
		peer.hold(3, 1'b0);
		wr(wdspc_pkg::WDSPC_UNITS_ADDR, 8'h80);
		wr(wdspc_pkg::WDSPC_TOVAL_ADDR, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr(wdspc_pkg::WDSPC_CFG_ADDR, 8'(1 << i));
			wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h00);
			repeat (8) begin
				peer.pulse(i);
				cyc(11);
			end
			rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h0);
			cyc(60);
			rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h1);
		end
		wr(wdspc_pkg::WDSPC_CFG_ADDR, 8'h00);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h00);
		for (int i = 0; i < 8; i++) begin
			peer.pulse(i % 3);
			cyc(11);
		end
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h1);
		wr(wdspc_pkg::WDSPC_TOVAL_ADDR, 8'h00);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h00);
		cyc(150);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h01, 32'h0);
		c0 = poff_cnt;
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h80);
		cyc(5);
		chk(32'(poff_cnt - c0), 32'h1);
		c0 = poff_cnt;
		peer.pulse(4);
		cyc(5);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h20);
		rchk(wdspc_pkg::WDSPC_CTRL_ADDR, 32'h20, 32'h20);
		cyc(60);
		chk(32'(poff_cnt - c0), 32'h0);
		peer.pulse(4);
		cyc(10);
		wr(wdspc_pkg::WDSPC_CTRL_ADDR, 8'h40);
		cyc(12);
		chk(32'(poff_cnt - c0), 32'h0);
		cyc(30);
		chk(32'(poff_cnt - c0), 32'h1);
		wr(wdspc_pkg::WDSPC_DLY_ADDR, 8'h02);
		c0 = poff_cnt;
		peer.pulse(4);
		cyc(14);
		chk(32'(poff_cnt - c0), 32'h1);
		complete_run();
	end
	initial begin
		#200000;
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run();
	end
endmodule // test_wdspc_top
